// ==== core/wwd_pkg.sv ====
// Package: constants and carrier types for the window watchdog supervisor
// Function
// [R1] Reset output asserted from power-up onward
// [R2] Supply below threshold drives reset low immediately
// [R3] Hold reset for release delay after supply good
// [R4] Trigger rising edge restarts timers, new window
// [R5] Straps select window length and boundary ratio
// [R6] Window 0.25 s low, 2.5 s high
// [R7] Short window boundary 7.86 ms or 2 ms
// [R8] Long window boundary 78.2 ms or 19.6 ms
// [R9] Boundaries stay inside their tolerance bands
// [R10] Processor triggers between boundary and window end
// [R11] Early trigger is violation, asserts reset
// [R12] Missing trigger by window end asserts reset
// [R13] First window after release skips boundary check
// [R14] First trigger enables boundary checking afterwards
// [R15] Processor keeps triggers clear of tolerance bands
// [R16] Trigger sampled on internal clock, next cycle
// [R17] Fault holds reset for delay, then restarts
package wwd_pkg;

	// ------------------------------------------------------------
	// Timing figures
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 25000000;
	localparam int unsigned CLK_PERIOD_NS   = 40;
	localparam int unsigned RELEASE_DELAY_US = 25000;   // 25 ms
	localparam int unsigned WIN_SHORT_US    = 250000;  // 0.25 s
	localparam int unsigned WIN_LONG_US     = 2500000; // 2.5 s
	localparam int unsigned BND_SS_NS       = 7860000; // 7.86 ms
	localparam int unsigned BND_SR_NS       = 2000000; // 2 ms
	localparam int unsigned BND_LS_US       = 78200;   // 78.2 ms
	localparam int unsigned BND_LR_US       = 19600;   // 19.6 ms

	// Cycle counts derived from the 25 MHz clock (typical values)
	localparam int unsigned RELEASE_DELAY_CYC = RELEASE_DELAY_US * (CLK_HZ / 1000000);
	localparam int unsigned WIN_SHORT_CYC     = WIN_SHORT_US * (CLK_HZ / 1000000);
	localparam int unsigned WIN_LONG_CYC      = WIN_LONG_US * (CLK_HZ / 1000000);
	localparam int unsigned BND_SS_CYC        = BND_SS_NS / CLK_PERIOD_NS;
	localparam int unsigned BND_SR_CYC        = BND_SR_NS / CLK_PERIOD_NS;
	localparam int unsigned BND_LS_CYC        = BND_LS_US * (CLK_HZ / 1000000);
	localparam int unsigned BND_LR_CYC        = BND_LR_US * (CLK_HZ / 1000000);

	localparam int unsigned CNT_W = 27;

	// Reset values
	localparam logic RST_ASSERTED = 1'b0;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_HOLD   = 2'b00, // Reset asserted, release timer running
		ST_FIRST  = 2'b01, // First window, boundary not checked
		ST_WATCH  = 2'b10  // Full window checking
	} sup_state_t;

	// Window limits handed from the selector to the supervisor
	typedef struct packed {
		logic [CNT_W-1:0] window_cyc;
		logic [CNT_W-1:0] boundary_cyc;
	} window_cfg_t;

endpackage

// ==== core/wwd_window_select.sv ====
// Window selector: maps the strap levels to window and boundary counts
`timescale 1ns/100ps
`default_nettype none
module wwd_window_select #(
	parameter int unsigned WIN_SHORT = wwd_pkg::WIN_SHORT_CYC,
	parameter int unsigned WIN_LONG  = wwd_pkg::WIN_LONG_CYC,
	parameter int unsigned BND_SS    = wwd_pkg::BND_SS_CYC,
	parameter int unsigned BND_SR    = wwd_pkg::BND_SR_CYC,
	parameter int unsigned BND_LS    = wwd_pkg::BND_LS_CYC,
	parameter int unsigned BND_LR    = wwd_pkg::BND_LR_CYC
) (
	// Strap levels, already synchronised
	input  wire logic                timeout_select,
	input  wire logic                ratio_select,
	// Selected limits
	output wwd_pkg::window_cfg_t     cfg
);

	// Four fixed timings; typical values sit inside every band
	always_comb begin
		case ({timeout_select, ratio_select})
			2'b00: begin
				cfg.window_cyc   = wwd_pkg::CNT_W'(WIN_SHORT); // [R6]
				cfg.boundary_cyc = wwd_pkg::CNT_W'(BND_SS);    // [R7] [R9]
			end
			2'b01: begin
				cfg.window_cyc   = wwd_pkg::CNT_W'(WIN_SHORT); // [R6]
				cfg.boundary_cyc = wwd_pkg::CNT_W'(BND_SR);    // [R7] [R9]
			end
			2'b10: begin
				cfg.window_cyc   = wwd_pkg::CNT_W'(WIN_LONG);  // [R6]
				cfg.boundary_cyc = wwd_pkg::CNT_W'(BND_LS);    // [R8] [R9]
			end
			default: begin
				cfg.window_cyc   = wwd_pkg::CNT_W'(WIN_LONG);  // [R6]
				cfg.boundary_cyc = wwd_pkg::CNT_W'(BND_LR);    // [R8] [R9]
			end
		endcase
	end

endmodule
`default_nettype wire

// ==== core/window_watchdog_supervisor.sv ====
// Top level: power-on reset generator and window watchdog
`timescale 1ns/100ps
`default_nettype none
module window_watchdog_supervisor #(
	parameter int unsigned RELEASE_DELAY = wwd_pkg::RELEASE_DELAY_CYC,
	parameter int unsigned WIN_SHORT     = wwd_pkg::WIN_SHORT_CYC,
	parameter int unsigned WIN_LONG      = wwd_pkg::WIN_LONG_CYC,
	parameter int unsigned BND_SS        = wwd_pkg::BND_SS_CYC,
	parameter int unsigned BND_SR        = wwd_pkg::BND_SR_CYC,
	parameter int unsigned BND_LS        = wwd_pkg::BND_LS_CYC,
	parameter int unsigned BND_LR        = wwd_pkg::BND_LR_CYC
) (
	// Clock and power-on reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Supply monitor and straps (asynchronous pins)
	input  wire logic supply_threshold,
	input  wire logic timeout_select,
	input  wire logic ratio_select,
	// Trigger from the supervised processor (asynchronous pin)
	input  wire logic watchdog_trigger_in,
	// Open-drain reset pin
	input  wire logic reset_b_in,
	output logic      reset_b_out,
	output logic      reset_b_oe_b,
	// Status
	output logic      timeout_flag,
	output logic      violation_flag
);

	// ------------------------------------------------------------
	// Supervisor state, declared first
	// ------------------------------------------------------------
	// The strap latch and the flag logic both look at the state, so
	// it is declared ahead of every process that reads it
	wwd_pkg::sup_state_t          state_reg;
	wwd_pkg::sup_state_t          state_next;
	logic [wwd_pkg::CNT_W-1:0]    cnt_reg;
	logic [wwd_pkg::CNT_W-1:0]    cnt_next;
	logic                         early;
	logic                         expired;
	logic                         released;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// Every pin is asynchronous to the internal clock; the first
	// stage may go metastable, so logic only ever reads the second
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic       trig_prev_reg;
	logic       supply_ok;
	logic       trig_rise;

	// Two flops per pin; only the second stage is read by logic
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
		end else begin
			sync1_reg <= {watchdog_trigger_in, ratio_select, timeout_select, supply_threshold};
			sync2_reg <= sync1_reg;
		end
	end

	// Edge detector on the synchronised trigger
	// It resets low, the idle level of the pin, so no false edge follows reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			trig_prev_reg <= 1'b0;
		end else begin
			trig_prev_reg <= sync2_reg[3];
		end
	end

	// Synchronised supply level and the one-cycle trigger edge; a trigger
	// takes effect three clocks after it reaches the pin
	assign supply_ok = sync2_reg[0];
	assign trig_rise = sync2_reg[3] & ~trig_prev_reg; // [R16]

	// ------------------------------------------------------------
	// Strap latching
	// ------------------------------------------------------------
	logic                 tsel_reg;
	logic                 rsel_reg;
	wwd_pkg::window_cfg_t cfg;

	// Straps are caught while reset is held, so the window cannot
	// change shape under a running count
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tsel_reg <= 1'b0;
			rsel_reg <= 1'b0;
		end else if (state_reg == wwd_pkg::ST_HOLD) begin
			tsel_reg <= sync2_reg[1]; // [R5]
			rsel_reg <= sync2_reg[2]; // [R5]
		end
	end

	// Limits are the typical figures only; each typical value lies
	// inside its tolerance band, so no band logic is built. Timing by
	// an external capacitor is not supported here.
	wwd_window_select #(
		.WIN_SHORT (WIN_SHORT),
		.WIN_LONG  (WIN_LONG),
		.BND_SS    (BND_SS),
		.BND_SR    (BND_SR),
		.BND_LS    (BND_LS),
		.BND_LR    (BND_LR)
	) u_select (
		.timeout_select (tsel_reg),
		.ratio_select   (rsel_reg),
		.cfg            (cfg)
	);

	// ------------------------------------------------------------
	// Supervisor state machine
	// ------------------------------------------------------------
	// Early: a trigger inside the lower boundary once checking is on.
	// Expired: the count reached the window end with no trigger; a
	// trigger in that same cycle still wins and restarts the window.
	// Released: the hold timer has run the full release delay.
	assign early    = (state_reg == wwd_pkg::ST_WATCH) && trig_rise
	                  && (cnt_reg < cfg.boundary_cyc);            // [R11]
	assign expired  = (state_reg != wwd_pkg::ST_HOLD) && !trig_rise
	                  && (cnt_reg >= cfg.window_cyc - 1'b1);       // [R12]
	assign released = (cnt_reg >= wwd_pkg::CNT_W'(RELEASE_DELAY) - 1'b1);

	// Next state and counter; supply loss overrides everything
	// The counter runs in every state; each new interval clears it
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg + 1'b1;
		if (!supply_ok) begin
			state_next = wwd_pkg::ST_HOLD;                       // [R2]
			cnt_next   = '0;                                     // [R3]
		end else begin
			case (state_reg)
				wwd_pkg::ST_HOLD: begin
					if (released) begin
						state_next = wwd_pkg::ST_FIRST;          // [R3] [R13]
						cnt_next   = '0;
					end
				end
				wwd_pkg::ST_FIRST: begin
					if (trig_rise) begin
						state_next = wwd_pkg::ST_WATCH;          // [R14]
						cnt_next   = '0;                         // [R4]
					end else if (expired) begin
						state_next = wwd_pkg::ST_HOLD;           // [R12] [R17]
						cnt_next   = '0;
					end
				end
				wwd_pkg::ST_WATCH: begin
					if (early || expired) begin
						state_next = wwd_pkg::ST_HOLD;           // [R11] [R12] [R17]
						cnt_next   = '0;
					end else if (trig_rise) begin
						cnt_next   = '0;                         // [R4]
					end
				end
				default: begin
					state_next = wwd_pkg::ST_HOLD;
					cnt_next   = '0;
				end
			endcase
		end
	end

	// State and timer registers; reset starts in the hold state
	// An unused state code falls back to hold through the default branch
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= wwd_pkg::ST_HOLD; // [R1]
			cnt_reg   <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	// ------------------------------------------------------------
	// Fault flags and reset pin
	// ------------------------------------------------------------
	// Flags stay set until the next release and clear on the same edge
	// that frees the reset pin; a new fault always wins over clearing
	// Both flags read zero while the hold timer runs after power-up
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timeout_flag   <= 1'b0;
			violation_flag <= 1'b0;
		end else begin
			if (state_next != wwd_pkg::ST_HOLD && state_reg == wwd_pkg::ST_HOLD) begin
				timeout_flag   <= 1'b0;
				violation_flag <= 1'b0;
			end
			if (supply_ok && expired) begin
				timeout_flag <= 1'b1;   // [R12]
			end
			if (supply_ok && early) begin
				violation_flag <= 1'b1; // [R11]
			end
		end
	end

	// Open drain: only ever pulls low; enable low means driving
	// Registered so the pin never glitches on a state decode
	logic pull_low_reg;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pull_low_reg <= 1'b1;                              // [R1]
		end else begin
			pull_low_reg <= (state_next == wwd_pkg::ST_HOLD);  // [R2] [R3]
		end
	end

	// Data is fixed low and only the enable moves, so the pin can be
	// shared with other open-drain reset sources on the board
	assign reset_b_out  = wwd_pkg::RST_ASSERTED;
	assign reset_b_oe_b = ~pull_low_reg;

endmodule
`default_nettype wire

// ==== test/wwd_trig_proc.sv ====
// Partner model: supervised processor driving the trigger pin
`timescale 1ns/100ps
`default_nettype none
module wwd_trig_proc (
	// Clock and command from the bench
	input  wire logic        clk,
	input  wire logic        go,
	input  wire logic [15:0] gap,
	// Trigger pin
	output logic             trig
);
	int unsigned cnt = 0;
	initial trig = 1'b0;
	// Rise gap+1 cycles after go is sampled, stay high two cycles; go drops the pin
	always @(posedge clk) begin
		if (go) cnt <= 32'(gap) + 2;
		else if (cnt != 0) cnt <= cnt - 1;
		trig <= (cnt == 2 || cnt == 1) && !go;
	end
endmodule
`default_nettype wire

// ==== test/wwd_chk.sv ====
// Checker: port assertions of the window watchdog supervisor
`timescale 1ns/100ps
`default_nettype none
module wwd_chk #(
	parameter int unsigned RELEASE_DELAY = 50,
	parameter int unsigned WIN_SHORT     = 400,
	parameter int unsigned WIN_LONG      = 800
) (
	// Watched ports
	input wire logic clk,
	input wire logic rst_b,
	input wire logic supply_threshold,
	input wire logic timeout_select,
	input wire logic watchdog_trigger_in,
	input wire logic reset_b_out,
	input wire logic reset_b_oe_b,
	input wire logic timeout_flag,
	input wire logic violation_flag
);
	int unsigned hold_cnt, trig_age, n_trig;
	logic        trig_q;
	int unsigned win_lim;
	// Window end follows the strap pin; six cycles cover sync latency
	assign win_lim = (timeout_select ? WIN_LONG : WIN_SHORT) + 6;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Ages measured at the pin, so sync latency is allowed for in the bounds
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_cnt <= 0;
			trig_age <= 0;
			n_trig <= 0;
			trig_q <= 1'b0;
		end else begin
			trig_q <= watchdog_trigger_in;
			hold_cnt <= (reset_b_oe_b || !supply_threshold) ? 0 : hold_cnt + 1;
			trig_age <= (!reset_b_oe_b || (watchdog_trigger_in && !trig_q)) ? 0 : trig_age + 1;
			n_trig <= !reset_b_oe_b ? 0 : n_trig + 32'(watchdog_trigger_in && !trig_q);
		end
	end
	sequence s_supply_lost;
		!supply_threshold [*6];
	endsequence
	sequence s_fault;
		$rose(timeout_flag) || $rose(violation_flag);
	endsequence
	AST_PIN_DATA_LOW: assert property (reset_b_out == 1'b0)
		else $error("reset pin data not low");
	AST_SUPPLY_LOST: assert property (s_supply_lost |-> !reset_b_oe_b)
		else $error("reset released with supply low");
	AST_RELEASE_DELAY: assert property ($rose(reset_b_oe_b) |-> hold_cnt >= RELEASE_DELAY)
		else $error("reset released too early");
	AST_WINDOW_END: assert property (reset_b_oe_b |-> trig_age <= win_lim)
		else $error("window expired without reset");
	AST_VIOL_CAUSE: assert property ($rose(violation_flag) |-> trig_age >= 1 && trig_age <= 6)
		else $error("violation without recent trigger");
	AST_FIRST_FREE: assert property ($rose(violation_flag) |-> n_trig >= 2)
		else $error("violation in first window");
	AST_FAULT_ASSERTS: assert property (s_fault |-> ##[0:1] !reset_b_oe_b)
		else $error("fault without reset");
	AST_FLAGS_CLEAR: assert property ($rose(reset_b_oe_b) |-> !timeout_flag && !violation_flag)
		else $error("flags not cleared on release");
endmodule
bind window_watchdog_supervisor wwd_chk #(.RELEASE_DELAY(RELEASE_DELAY), .WIN_SHORT(WIN_SHORT),
	.WIN_LONG(WIN_LONG)) i_chk (
	.clk(clk), .rst_b(rst_b), .supply_threshold(supply_threshold),
	.timeout_select(timeout_select),
	.watchdog_trigger_in(watchdog_trigger_in), .reset_b_out(reset_b_out),
	.reset_b_oe_b(reset_b_oe_b), .timeout_flag(timeout_flag), .violation_flag(violation_flag));
`default_nettype wire

// ==== test/testbench.sv ====
// Testbench: strap combinations, trigger windows, faults and supply loss
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam int RD = 50;
	localparam int WS = 400, WL = 800, BSS = 40, BSR = 10, BLS = 100, BLR = 30;
	logic clk = 1'b0, rst_b = 1'b0, supply = 1'b0, tsel = 1'b0, rsel = 1'b0, go = 1'b0;
	logic [15:0] gap = '0;
	logic trig, oe_b, pin_out, tmo, viol;
	wire reset_pin = oe_b ? 1'b1 : pin_out; // Pull-up on the open-drain pin
	int n_fail = 0, n_checks = 0, n, w, b;
	int unsigned seed = 47;
	int win_t[2] = '{WS, WL};
	int bnd_t[4] = '{BSS, BSR, BLS, BLR};
	window_watchdog_supervisor #(.RELEASE_DELAY(RD), .WIN_SHORT(WS), .WIN_LONG(WL),
		.BND_SS(BSS), .BND_SR(BSR), .BND_LS(BLS), .BND_LR(BLR)) i_window_watchdog_supervisor (
		.clk(clk), .rst_b(rst_b), .supply_threshold(supply), .timeout_select(tsel),
		.ratio_select(rsel), .watchdog_trigger_in(trig), .reset_b_in(reset_pin),
		.reset_b_out(pin_out), .reset_b_oe_b(oe_b), .timeout_flag(tmo), .violation_flag(viol));
	wwd_trig_proc i_wwd_trig_proc (.clk(clk), .go(go), .gap(gap), .trig(trig));
	initial forever #20 clk = ~clk;
	function automatic int unsigned xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s exp %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic wait_oe(input logic v, output int k);
		k = 0;
		while (oe_b !== v && k < 5000) begin
			step();
			k++;
		end
	endtask
	task automatic trig_at(input int g);
		go = 1'b1;
		gap = 16'(g);
		step();
		go = 1'b0;
		while (trig !== 1'b1) step();
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Hang guard sized well above four strap passes
	initial begin
		repeat (40000) @(posedge clk);
		n_fail++;
		summarize();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) step();
		check("oe_in_reset", oe_b, 1'b0);
		rst_b = 1'b1;
		for (int i = 0; i < 4; i++) begin
			tsel = i[1];
			rsel = i[0];
			w = win_t[i / 2];
			b = bnd_t[i];
			supply = 1'b0;
			repeat (6) step();
			supply = 1'b1;
			wait_oe(1'b1, n);
			check("release_delay", n >= RD && n <= RD + 5, 1);
			trig_at(3);
			trig_at(b + 6 + int'(xs() % 32'(w - b - 30)));
			repeat (8) step();
			check("in_window", {oe_b, viol}, 2'b10);
			supply = 1'b0;
			repeat (6) step();
			check("supply_drop", oe_b, 1'b0);
			supply = 1'b1;
			wait_oe(1'b1, n);
			trig_at(3);
			trig_at(b - 3);
			repeat (8) step();
			check("early_trig", {oe_b, viol, tmo}, 3'b010);
			wait_oe(1'b1, n);
			check("fault_hold", n + 8 >= RD && n <= RD, 1);
			wait_oe(1'b0, n);
			check("window_len", n >= w - 2 && n <= w + 4, 1);
			check("timeout_flag", {tmo, viol}, 2'b10);
			$display("strap pass %0d done", i);
		end
		summarize();
	end
endmodule
`default_nettype wire
